//--- design/timer_mode_control.sv
// Mode, control, count and compare logic for three 16-bit timers behind AXI4-Lite.
// Assumes pin inputs are asynchronous and irq_ack comes from logic on clk.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module timer_mode_control
	import timer_mode_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic timer0_pin_input,
	input wire logic timer1_pin_input,
	input wire logic [2:0] irq_ack,
	output logic [2:0] timer_irq
);

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_have;
		logic w_have;
		logic [ADDR_W-1:0] awaddr;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [1:0] div;
		logic [1:0] pin_s1;
		logic [1:0] pin_s2;
		logic [1:0] pin_s3;
		logic [2:0] en;
		logic [2:0] ie;
		logic [2:0] compare_b_in_use;
		logic [2:0] mc;
		logic [2:0] retrigger;
		logic [2:0] pre;
		logic [2:0] outside_clock_select;
		logic [2:0] dual_limit_select;
		logic [2:0] free_running;
		logic [2:0] irq;
		logic [2:0][15:0] count;
		logic [2:0][15:0] cmpa;
		logic [2:0][15:0] cmpb;
	} state_t;

	state_t r;
	state_t nx;

	logic [2:0] tick;
	logic [2:0] hit;
	logic [2:0] stop;
	logic [2:0] wr_touch;
	logic [1:0] pin_edge;
	logic div_tick;
	logic src;
	logic [15:0] inc;
	logic [15:0] limit;
	logic [15:0] cur;
	logic [15:0] mask;
	logic [15:0] wv;
	reg_sel_t wsel;
	reg_sel_t rsel;
	int t;

	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		logic [9:0] idx;
		s = '{ok: 1'b0, kind: KIND_CTRL, tmr: 2'd0};
		idx = a[ADDR_W-1:2];
		for (int k = 0; k < 3; k++)
		begin
			if (idx == IDX_CTRL[k])
				s = '{ok: 1'b1, kind: KIND_CTRL, tmr: 2'(k)};
			else if (idx == IDX_CNT[k])
				s = '{ok: 1'b1, kind: KIND_CNT, tmr: 2'(k)};
			else if (idx == IDX_CMPA[k])
				s = '{ok: 1'b1, kind: KIND_CMPA, tmr: 2'(k)};
			else if (k != 2 && idx == IDX_CMPB[k])
				s = '{ok: 1'b1, kind: KIND_CMPB, tmr: 2'(k)};
		end
		return s;
	endfunction : decode

	function automatic logic [15:0] read_word(input state_t s, input reg_sel_t sel);
		logic [15:0] v;
		logic [1:0] k;
		v = WORD_RESET;
		k = sel.tmr;
		if (sel.kind == KIND_CTRL)
		begin
			v[GATE_BIT] = 1'b0;
			v[EN_BIT] = s.en[k];
			v[IE_BIT] = s.ie[k];
			v[MC_BIT] = s.mc[k];
			v[FREE_RUNNING_BIT] = s.free_running[k];
			if (k != 2'd2)
			begin
				v[RIU_BIT] = s.compare_b_in_use[k];
				v[RTG_BIT] = s.retrigger[k];
				v[PRE_BIT] = s.pre[k];
				v[EXT_BIT] = s.outside_clock_select[k];
				v[ALT_BIT] = s.dual_limit_select[k];
			end
		end
		else if (sel.kind == KIND_CNT)
			v = s.count[k];
		else if (sel.kind == KIND_CMPA)
			v = s.cmpa[k];
		else
			v = s.cmpb[k];
		return v;
	endfunction : read_word

	always_comb
	begin
		nx = r;
		tick = '0;
		hit = '0;
		stop = '0;
		wr_touch = '0;
		src = 1'b0;
		inc = WORD_RESET;
		limit = WORD_RESET;
		cur = WORD_RESET;
		mask = WORD_RESET;
		wv = WORD_RESET;
		t = 0;
		wsel = decode(r.awaddr);
		rsel = decode(araddr);

		nx.pin_s1 = {timer1_pin_input, timer0_pin_input};
		nx.pin_s2 = r.pin_s1;
		nx.pin_s3 = r.pin_s2;
		pin_edge = r.pin_s2 & ~r.pin_s3;
		div_tick = (r.div == DIV_LAST);
		nx.div = r.div + 2'd1;

		// Timer2 first so its terminal count can prescale the others
		for (int i = 0; i < 3; i++)
		begin
			t = 2 - i;
			if (t == 2)
				src = div_tick;
			else if (r.outside_clock_select[t])
				src = pin_edge[t];
			else if (r.pre[t])
				src = hit[2];
			else
				src = div_tick;
			tick[t] = r.en[t] & src;
			limit = (r.dual_limit_select[t] && r.compare_b_in_use[t]) ? r.cmpb[t] : r.cmpa[t];
			inc = r.count[t] + 16'h0001;
			if (tick[t])
			begin
				// wrap of inc makes zero limit span 16 bits
				if (inc == limit)
				begin
					hit[t] = 1'b1;
					nx.count[t] = WORD_RESET;
					nx.mc[t] = 1'b1;
					if (r.ie[t])
						nx.irq[t] = 1'b1;
					if (r.dual_limit_select[t])
						nx.compare_b_in_use[t] = ~r.compare_b_in_use[t];
					// single run ends after A, or after B in dual mode
					if (!r.free_running[t] && (!r.dual_limit_select[t] || r.compare_b_in_use[t]))
						stop[t] = 1'b1;
				end
				else
					nx.count[t] = inc;
			end
			if (irq_ack[t] && !(hit[t] && r.ie[t]))
				nx.irq[t] = 1'b0;
		end

		if (r.bvalid && bready)
			nx.bvalid = 1'b0;

		if (r.aw_have && r.w_have && !r.bvalid)
		begin
			nx.aw_have = 1'b0;
			nx.w_have = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = wsel.ok ? RESP_OKAY : RESP_SLVERR;
			wr_touch[wsel.tmr] = wsel.ok;
			cur = read_word(r, wsel);
			mask = {{8{r.wstrb[1]}}, {8{r.wstrb[0]}}};
			wv = (cur & ~mask) | (r.wdata & mask);
			if (wsel.ok)
			begin
				t = int'(wsel.tmr);
				if (wsel.kind == KIND_CTRL)
				begin
					// enable only moves with the gate
					if (wv[GATE_BIT])
						nx.en[t] = wv[EN_BIT];
					nx.ie[t] = wv[IE_BIT];
					// Hardware set wins over a clearing write
					nx.mc[t] = wv[MC_BIT] | hit[t];
					nx.free_running[t] = wv[FREE_RUNNING_BIT];
					if (t != 2)
					begin
						nx.retrigger[t] = wv[RTG_BIT];
						nx.pre[t] = wv[PRE_BIT];
						nx.outside_clock_select[t] = wv[EXT_BIT];
						nx.dual_limit_select[t] = wv[ALT_BIT];
					end
				end
				else if (wsel.kind == KIND_CNT)
					nx.count[t] = wv;
				else if (wsel.kind == KIND_CMPA)
					nx.cmpa[t] = wv;
				else
					nx.cmpb[t] = wv;
			end
		end

		for (int i = 0; i < 3; i++)
		begin
			// run end clears enable, even over a same-cycle write
			if (stop[i])
				nx.en[i] = 1'b0;
			// B limit unused outside dual mode
			if (!nx.dual_limit_select[i])
				nx.compare_b_in_use[i] = 1'b0;
		end

		if (awvalid && r.awready)
		begin
			nx.aw_have = 1'b1;
			nx.awaddr = awaddr;
		end
		if (wvalid && r.wready)
		begin
			nx.w_have = 1'b1;
			nx.wdata = wdata[15:0];
			nx.wstrb = wstrb[1:0];
		end
		// One write in flight; address and data may arrive in either order
		nx.awready = !nx.aw_have && !nx.bvalid;
		nx.wready = !nx.w_have && !nx.bvalid;

		if (r.rvalid && rready)
			nx.rvalid = 1'b0;
		if (arvalid && r.arready)
		begin
			nx.rvalid = 1'b1;
			nx.rresp = rsel.ok ? RESP_OKAY : RESP_SLVERR;
			nx.rdata = rsel.ok ? {16'h0000, read_word(r, rsel)} : 32'h0000_0000;
		end
		nx.arready = !nx.rvalid;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			r <= '0;
		else
			r <= nx;
	end

	assign awready = r.awready;
	assign wready = r.wready;
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign arready = r.arready;
	assign rvalid = r.rvalid;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign timer_irq = r.irq;

	// Helper: remembers whether the pending read targets a control word
	logic rd_ctrl_q;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rd_ctrl_q <= 1'b0;
		else if (arvalid && r.arready)
			rd_ctrl_q <= rsel.ok && (rsel.kind == KIND_CTRL);
	end

	property p_gate_reads_zero;
		@(posedge clk) disable iff (rst)
		r.rvalid && rd_ctrl_q |-> r.rdata[GATE_BIT] == 1'b0;
	endproperty
	a_gate_reads_zero: assert property (p_gate_reads_zero) else $error("gate bit read back as one");

	property p_hold_when_disabled;
		@(posedge clk) disable iff (rst)
		!r.en[0] && !wr_touch[0] |=> r.count[0] == $past(r.count[0]);
	endproperty
	a_hold_when_disabled: assert property (p_hold_when_disabled) else $error("disabled timer0 counted");

	property p_gate_required;
		@(posedge clk) disable iff (rst)
		r.aw_have && r.w_have && !r.bvalid && wsel.ok && wsel.kind == KIND_CTRL && wsel.tmr == 2'd1
			&& !wv[GATE_BIT] && !stop[1] |=> r.en[1] == $past(r.en[1]);
	endproperty
	a_gate_required: assert property (p_gate_required) else $error("enable changed without gate");

	property p_irq_on_hit;
		@(posedge clk) disable iff (rst)
		hit[0] && r.ie[0] |=> r.irq[0] ##1 (r.irq[0] || $past(irq_ack[0]));
	endproperty
	a_irq_on_hit: assert property (p_irq_on_hit) else $error("no request on terminal count");

	property p_irq_cause;
		@(posedge clk) disable iff (rst)
		$rose(r.irq[1]) |-> $past(hit[1] && r.ie[1]);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("request without enabled terminal count");

	property p_irq_holds;
		@(posedge clk) disable iff (rst)
		r.irq[0] && !irq_ack[0] |=> r.irq[0];
	endproperty
	a_irq_holds: assert property (p_irq_holds) else $error("pending request dropped");

	property p_mc_on_hit;
		@(posedge clk) disable iff (rst)
		hit[1] && !wr_touch[1] |=> r.mc[1] && r.count[1] == 16'h0000;
	endproperty
	a_mc_on_hit: assert property (p_mc_on_hit) else $error("flag or clear missing at limit");

	property p_riu_toggle;
		@(posedge clk) disable iff (rst)
		hit[1] && r.dual_limit_select[1] && !wr_touch[1] |=> r.compare_b_in_use[1] != $past(r.compare_b_in_use[1]);
	endproperty
	a_riu_toggle: assert property (p_riu_toggle) else $error("limit select did not alternate");

	property p_single_stop;
		@(posedge clk) disable iff (rst)
		hit[0] && !r.free_running[0] && (!r.dual_limit_select[0] || r.compare_b_in_use[0]) |=> !r.en[0];
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("single run kept enable");

	property p_ext_edge_only;
		@(posedge clk) disable iff (rst)
		r.outside_clock_select[1] && !pin_edge[1] && !wr_touch[1] |=> r.count[1] == $past(r.count[1]);
	endproperty
	a_ext_edge_only: assert property (p_ext_edge_only) else $error("outside clocked timer moved without edge");

	property p_prescale_step;
		@(posedge clk) disable iff (rst)
		r.en[0] && !r.outside_clock_select[0] && r.pre[0] && hit[2] && !hit[0] && !wr_touch[0]
			|=> r.count[0] == $past(r.count[0]) + 16'h0001;
	endproperty
	a_prescale_step: assert property (p_prescale_step) else $error("prescaled step missing");

	c_dual_b_hit: cover property (@(posedge clk) disable iff (rst) hit[1] && r.dual_limit_select[1] && r.compare_b_in_use[1]);
	c_irq_ack: cover property (@(posedge clk) disable iff (rst) r.irq[1] && irq_ack[1]);
	c_ext_count: cover property (@(posedge clk) disable iff (rst) tick[1] && r.outside_clock_select[1]);
	c_prescale_hit: cover property (@(posedge clk) disable iff (rst) hit[0] && r.pre[0] && !r.outside_clock_select[0]);

endmodule : timer_mode_control

`default_nettype wire

//--- design/timer_mode_pkg.sv
// Package for the three-timer mode and control block.
// Assumes a 32-bit AXI4-Lite master and a 20 MHz processor clock.
package timer_mode_pkg;

	// Register indices; byte address is four times the index
	localparam int ADDR_W = 12;
	localparam logic [9:0] IDX_T0_CNT = 10'h050;
	localparam logic [9:0] IDX_T0_CMPA = 10'h052;
	localparam logic [9:0] IDX_T0_CMPB = 10'h054;
	localparam logic [9:0] IDX_T0_CTRL = 10'h056;
	localparam logic [9:0] IDX_T1_CNT = 10'h058;
	localparam logic [9:0] IDX_T1_CMPA = 10'h05a;
	localparam logic [9:0] IDX_T1_CMPB = 10'h05c;
	localparam logic [9:0] IDX_T1_CTRL = 10'h05e;
	localparam logic [9:0] IDX_T2_CNT = 10'h060;
	localparam logic [9:0] IDX_T2_CMPA = 10'h062;
	localparam logic [9:0] IDX_T2_CTRL = 10'h066;
	localparam logic [9:0] IDX_NONE = 10'h3ff;

	localparam logic [2:0][9:0] IDX_CTRL = {IDX_T2_CTRL, IDX_T1_CTRL, IDX_T0_CTRL};
	localparam logic [2:0][9:0] IDX_CNT = {IDX_T2_CNT, IDX_T1_CNT, IDX_T0_CNT};
	localparam logic [2:0][9:0] IDX_CMPA = {IDX_T2_CMPA, IDX_T1_CMPA, IDX_T0_CMPA};
	localparam logic [2:0][9:0] IDX_CMPB = {IDX_NONE, IDX_T1_CMPB, IDX_T0_CMPB};

	// Control word bit positions
	localparam int EN_BIT = 15;
	localparam int GATE_BIT = 14;
	localparam int IE_BIT = 13;
	localparam int RIU_BIT = 12;
	localparam int MC_BIT = 5;
	localparam int RTG_BIT = 4;
	localparam int PRE_BIT = 3;
	localparam int EXT_BIT = 2;
	localparam int ALT_BIT = 1;
	localparam int FREE_RUNNING_BIT = 0;

	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// Internal count rate: one step per four processor clocks
	localparam int DIV_RATIO = 4;
	localparam logic [1:0] DIV_LAST = 2'(DIV_RATIO - 1);

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		KIND_CTRL = 2'b00,
		KIND_CNT = 2'b01,
		KIND_CMPA = 2'b10,
		KIND_CMPB = 2'b11
	} reg_kind_t;

	typedef struct packed {
		logic ok;
		reg_kind_t kind;
		logic [1:0] tmr;
	} reg_sel_t;

endpackage : timer_mode_pkg

//--- verif/tb_timer_mode_control.sv
// Self-checking bench for the three-timer mode and control block.
// Assumes AXI4-Lite register access on a 20 MHz clock and level interrupt service.
`timescale 1ns/1ps
`default_nettype none

module tb_timer_mode_control
	import timer_mode_pkg::*;
;
	logic clk = 0;
	logic rst = 1;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rv, c1, c2;
	logic [3:0] wstrb = '0;
	logic [1:0] bresp, rresp, rs;
	logic awready, wready, bvalid, arready, rvalid;
	logic timer0_pin_input = 0, timer1_pin_input = 0;
	logic [2:0] irq_ack = '0, timer_irq;
	int err_total = 0, compares = 0;

	always #25 clk = ~clk;

	timer_mode_control timer_mode_control_i (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'b000), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'b000), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.timer0_pin_input(timer0_pin_input), .timer1_pin_input(timer1_pin_input), .irq_ack(irq_ack),
		.timer_irq(timer_irq));

	task complete_run;
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task bad(input string m);
		err_total++;
		$display("BAD %0t %s", $time, m);
		complete_run();
	endtask : bad

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	// Address and data offered together, each dropped once taken
	task wr(input logic [9:0] idx, input logic [15:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= {idx, 2'b00};
		wvalid <= 1'b1;
		wdata <= {16'h0000, d};
		wstrb <= 4'hf;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!bvalid && n < 100);
		if (!bvalid)
			bad("write hang");
		bready <= 1'b0;
		r = bresp;
	endtask : wr

	task rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= {idx, 2'b00};
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!rvalid && n < 100);
		if (!rvalid)
			bad("read hang");
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask : rd

	task w(input logic [9:0] idx, input logic [15:0] d);
		wr(idx, d, rs);
	endtask : w

	task rchk(input logic [9:0] idx, input logic [31:0] exp);
		rd(idx, rv, rs);
		chk(rv, exp);
	endtask : rchk

	task wait_irq(input int t);
		int n;
		for (n = 0; n < 400 && timer_irq[t] !== 1'b1; n++)
			@(posedge clk);
		if (timer_irq[t] !== 1'b1)
			bad("no interrupt");
	endtask : wait_irq

	task ack;
		@(posedge clk);
		irq_ack <= 3'b111;
		@(posedge clk);
		irq_ack <= 3'b000;
		// Let the cleared request settle before anyone samples it
		@(posedge clk);
	endtask : ack

	task pin_pulses(input logic [1:0] which, input int k);
		repeat (k)
		begin
			@(posedge clk);
			timer0_pin_input <= which[0];
			timer1_pin_input <= which[1];
			repeat (3) @(posedge clk);
			timer0_pin_input <= 1'b0;
			timer1_pin_input <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask : pin_pulses

	task sc_reset;
		rchk(IDX_T0_CTRL, 32'h0000_0000);
		rchk(IDX_T1_CTRL, 32'h0000_0000);
		rchk(IDX_T2_CTRL, 32'h0000_0000);
		rd(10'h070, rv, rs);
		chk({rv[29:0], rs}, {30'h0, RESP_SLVERR});
		wr(10'h070, 16'h1234, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
	endtask : sc_reset

	task sc_gate;
		w(IDX_T1_CTRL, 16'h8000);
		rchk(IDX_T1_CTRL, 32'h0000_0000);
		w(IDX_T1_CTRL, 16'ha000);
		rchk(IDX_T1_CTRL, 32'h0000_2000);
		w(IDX_T1_CTRL, 16'hc000);
		rchk(IDX_T1_CTRL, 32'h0000_8000);
		w(IDX_T1_CTRL, 16'h0000);
		rchk(IDX_T1_CTRL, 32'h0000_8000);
		w(IDX_T1_CTRL, 16'h4000);
		rchk(IDX_T1_CTRL, 32'h0000_0000);
	endtask : sc_gate

	task sc_single;
		w(IDX_T0_CMPA, 16'h0003);
		w(IDX_T0_CTRL, 16'he000);
		wait_irq(0);
		rchk(IDX_T0_CTRL, 32'h0000_2020);
		chk(32'(timer_irq[0]), 32'h0000_0001);
		rchk(IDX_T0_CNT, 32'h0000_0000);
		ack();
		chk(32'(timer_irq[0]), 32'h0000_0000);
	endtask : sc_single

	task sc_dual;
		w(IDX_T1_CMPA, 16'h0002);
		w(IDX_T1_CMPB, 16'h0006);
		w(IDX_T1_CNT, 16'h0000);
		w(IDX_T1_CTRL, 16'he003);
		wait_irq(1);
		rchk(IDX_T1_CTRL, 32'h0000_b023);
		ack();
		// Rewrite clears the flag so the B hit must set it again
		w(IDX_T1_CTRL, 16'he003);
		wait_irq(1);
		rchk(IDX_T1_CTRL, 32'h0000_a023);
		w(IDX_T1_CTRL, 16'h4000);
		ack();
		// Single run in dual mode must pass A and stop on B
		w(IDX_T1_CNT, 16'h0000);
		w(IDX_T1_CTRL, 16'hc002);
		repeat (60) @(posedge clk);
		rchk(IDX_T1_CTRL, 32'h0000_0022);
		rchk(IDX_T1_CNT, 32'h0000_0000);
	endtask : sc_dual

	task sc_noirq;
		w(IDX_T0_CMPA, 16'h0002);
		w(IDX_T0_CTRL, 16'hc001);
		repeat (40)
		begin
			@(posedge clk);
			if (timer_irq[0] !== 1'b0)
				chk(32'(timer_irq[0]), 32'h0000_0000);
		end
		rchk(IDX_T0_CTRL, 32'h0000_8021);
		w(IDX_T0_CTRL, 16'h4000);
		rd(IDX_T0_CNT, c1, rs);
		repeat (20) @(posedge clk);
		rchk(IDX_T0_CNT, c1);
	endtask : sc_noirq

	task sc_ext;
		w(IDX_T0_CNT, 16'h0000);
		w(IDX_T1_CNT, 16'h0000);
		w(IDX_T0_CMPA, 16'h0000);
		w(IDX_T1_CMPA, 16'h0000);
		w(IDX_T0_CTRL, 16'hc005);
		w(IDX_T1_CTRL, 16'hc00d);
		pin_pulses(2'b10, 5);
		repeat (6) @(posedge clk);
		rchk(IDX_T1_CNT, 32'h0000_0005);
		rchk(IDX_T0_CNT, 32'h0000_0000);
		pin_pulses(2'b01, 2);
		repeat (6) @(posedge clk);
		rchk(IDX_T0_CNT, 32'h0000_0002);
		rchk(IDX_T1_CNT, 32'h0000_0005);
		w(IDX_T0_CTRL, 16'h4000);
		w(IDX_T1_CTRL, 16'h4000);
	endtask : sc_ext

	task sc_prescale;
		w(IDX_T0_CMPA, 16'h0000);
		w(IDX_T0_CNT, 16'h0000);
		w(IDX_T0_CTRL, 16'hc001);
		repeat (40) @(posedge clk);
		rd(IDX_T0_CNT, c1, rs);
		// 42 edges lie between enable and capture, so the divider gives 10 or 11
		chk(32'(c1 >= 32'd10 && c1 <= 32'd11), 32'h0000_0001);
		w(IDX_T0_CTRL, 16'hc009);
		w(IDX_T0_CNT, 16'h0000);
		repeat (40) @(posedge clk);
		rchk(IDX_T0_CNT, 32'h0000_0000);
		w(IDX_T2_CMPA, 16'h0002);
		w(IDX_T2_CTRL, 16'hc001);
		repeat (40) @(posedge clk);
		w(IDX_T2_CTRL, 16'h4000);
		rd(IDX_T0_CNT, c1, rs);
		chk(32'(c1 != 0), 32'h0000_0001);
		repeat (20) @(posedge clk);
		rchk(IDX_T0_CNT, c1);
	endtask : sc_prescale

	task sc_access;
		w(IDX_T2_CTRL, 16'he021);
		wait_irq(2);
		rchk(IDX_T2_CTRL, 32'h0000_a021);
		w(IDX_T2_CTRL, 16'h4000);
		chk(32'(timer_irq[2]), 32'h0000_0001);
		rchk(IDX_T2_CTRL, 32'h0000_0000);
		ack();
		chk(32'(timer_irq[2]), 32'h0000_0000);
		w(IDX_T0_CTRL, 16'hf03f);
		rchk(IDX_T0_CTRL, 32'h0000_a03f);
		w(IDX_T0_CTRL, 16'h4000);
		rchk(IDX_T0_CTRL, 32'h0000_0000);
	endtask : sc_access

	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		sc_reset();
		sc_gate();
		sc_single();
		sc_dual();
		sc_noirq();
		sc_ext();
		sc_prescale();
		sc_access();
		complete_run();
	end

endmodule : tb_timer_mode_control

`default_nettype wire
